/* hw/gpio_port.sv */
/*
 * general-purpose pin port: register file on the word-addressed i/o port,
 * pin direction, output levels, pulldown controls, edge flags, interrupt.
 * assumes one system clock, asynchronous pins, and a cpu port that holds
 * address and data for the strobe cycle.
 */
`include "gpio_port_consts.svh"

module gpio_port
  import gpio_port_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_n_i,
  // cpu register port
  input  wire logic [15:0]           reg_addr_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic [15:0]           reg_wdata_i,
  output      logic [15:0]           reg_rdata_o,
  output      logic                  reg_ack_o,
  // pins
  input  wire logic [`PIN_COUNT-1:0] port_pin_in_i,
  output      logic [`PIN_COUNT-1:0] port_pin_out_o,
  output      logic [`PIN_COUNT-1:0] port_pin_oe_n_o,
  output      logic [`PIN_COUNT-1:0] internal_pulldown_o,
  output      logic                  output_only_pin_o,
  // interrupt
  output      logic                  irq_o
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic reg_sel_type decode_sel(logic [15:0] a);
    reg_sel_type s;
    s = SEL_NONE;
    if (a == `ADDR_DIR_LO  || a == `ADDR_DIR_HI)  s = SEL_DIR;
    if (a == `ADDR_DIN_LO  || a == `ADDR_DIN_HI)  s = SEL_DIN;
    if (a == `ADDR_DOUT_LO || a == `ADDR_DOUT_HI) s = SEL_DOUT;
    if (a == `ADDR_EDGE_LO || a == `ADDR_EDGE_HI) s = SEL_EDGE;
    if (a == `ADDR_IEN_LO  || a == `ADDR_IEN_HI)  s = SEL_IEN;
    if (a == `ADDR_FLG_LO  || a == `ADDR_FLG_HI)  s = SEL_FLG;
    if (a == `ADDR_PD_LO   || a == `ADDR_PD_HI)   s = SEL_PD;
    if (a == `ADDR_XF)                            s = SEL_XF;
    return s;
  endfunction

  // merges one 16-bit half into a pin vector
  function automatic pins_type merge_half(pins_type old, word_type d, logic hi);
    pins_type r;
    r = old;
    if (hi) begin
      r[`PIN_COUNT-1:`WORD_BITS] = d[`HI_BITS-1:0];
    end else begin
      r[`WORD_BITS-1:0] = d;
    end
    return r;
  endfunction

  // picks one 16-bit half of a pin vector, unused high bits read zero
  function automatic word_type pick_half(pins_type v, logic hi);
    return hi ? {{(`WORD_BITS-`HI_BITS){1'b0}}, v[`PIN_COUNT-1:`WORD_BITS]}
              : v[`WORD_BITS-1:0];
  endfunction

  // ****************************************
  // registers
  // ****************************************
  pins_type dir_q;
  pins_type dout_q;
  pins_type edge_q;
  pins_type ien_q;
  pins_type flag_q;
  pins_type flag_d;
  pins_type pd_dis_q;
  logic     xf_q;
  logic     irq_q;
  word_type rdata_q;
  logic     ack_q;

  // ****************************************
  // pin path
  // ****************************************
  pin_path_if #(.W(`PIN_COUNT)) pp ();

  pin_sampler #(
    .W      (`PIN_COUNT),
    .STAGES (`FLAG_LAT_CYC),
    .TAP    (`DIN_LAT_CYC)
  ) u_sampler (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .pp         (pp.sampler)
  );

  pin_driver #(
    .W    (`PIN_COUNT),
    .HOLD (`OUT_HOLD_CYC)
  ) u_driver (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .pp         (pp.driver)
  );

  assign pp.raw        = port_pin_in_i;
  assign pp.want_level = {xf_q, dout_q};                              // R2 R4
  assign pp.want_drive = dir_q;                                       // R1

  // ****************************************
  // address decode and strobes
  // ****************************************
  reg_sel_type sel_w;
  logic        hi_w;
  logic        wr_dir_w;
  logic        wr_dout_w;
  logic        wr_edge_w;
  logic        wr_ien_w;
  logic        wr_flg_w;
  logic        wr_pd_w;
  logic        wr_xf_w;

  assign sel_w     = decode_sel(reg_addr_i);
  assign hi_w      = reg_addr_i[0];                                   // R7
  assign wr_dir_w  = reg_wr_i && sel_w == SEL_DIR;
  assign wr_dout_w = reg_wr_i && sel_w == SEL_DOUT;
  assign wr_edge_w = reg_wr_i && sel_w == SEL_EDGE;
  assign wr_ien_w  = reg_wr_i && sel_w == SEL_IEN;
  assign wr_flg_w  = reg_wr_i && sel_w == SEL_FLG;
  assign wr_pd_w   = reg_wr_i && sel_w == SEL_PD;
  assign wr_xf_w   = reg_wr_i && sel_w == SEL_XF;

  // ****************************************
  // edge events and flags
  // ****************************************
  pins_type evt_w;
  pins_type clr_w;

  assign evt_w  = ~dir_q & ((edge_q & pp.rise) | (~edge_q & pp.fall));      // R6 R9
  assign clr_w  = wr_flg_w ? merge_half('0, reg_wdata_i, hi_w) : '0;        // R15
  assign flag_d = (flag_q & ~clr_w) | evt_w;                                 // R9 R15

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dir_q    <= `RST_PINS;
      dout_q   <= `RST_PINS;
      edge_q   <= `RST_PINS;
      ien_q    <= `RST_PINS;
      pd_dis_q <= `RST_PINS;
      xf_q     <= `RST_XF;
    end else begin
      if (wr_dir_w)  dir_q    <= merge_half(dir_q, reg_wdata_i, hi_w);      // R1
      if (wr_dout_w) dout_q   <= merge_half(dout_q, reg_wdata_i, hi_w);     // R2
      if (wr_edge_w) edge_q   <= merge_half(edge_q, reg_wdata_i, hi_w);     // R6
      if (wr_ien_w)  ien_q    <= merge_half(ien_q, reg_wdata_i, hi_w);      // R8
      if (wr_pd_w)   pd_dis_q <= merge_half(pd_dis_q, reg_wdata_i, hi_w);   // R5
      if (wr_xf_w)   xf_q     <= reg_wdata_i[0];                            // R4
    end
  end

  // ****************************************
  // flags and interrupt line
  // ****************************************
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_q <= `RST_PINS;
      irq_q  <= 1'b0;
    end else begin
      flag_q <= flag_d;
      irq_q  <= |(flag_q & ien_q);                                    // R8 R16
    end
  end

  // ****************************************
  // read path
  // ****************************************
  word_type rd_word_w;

  always_comb begin
    unique case (sel_w)
      SEL_DIR:  rd_word_w = pick_half(dir_q, hi_w);
      SEL_DIN:  rd_word_w = pick_half(pp.level, hi_w);                // R3 R14
      SEL_DOUT: rd_word_w = pick_half(dout_q, hi_w);
      SEL_EDGE: rd_word_w = pick_half(edge_q, hi_w);
      SEL_IEN:  rd_word_w = pick_half(ien_q, hi_w);
      SEL_FLG:  rd_word_w = pick_half(flag_q, hi_w);
      SEL_PD:   rd_word_w = pick_half(pd_dis_q, hi_w);
      SEL_XF:   rd_word_w = {15'h0000, xf_q};
      SEL_NONE: rd_word_w = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= 16'h0000;
      ack_q   <= 1'b0;
    end else begin
      ack_q <= reg_rd_i | reg_wr_i;
      if (reg_rd_i) rdata_q <= rd_word_w;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic [`PIN_COUNT-1:0] pd_on_q;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pd_on_q <= '1;
    end else begin
      pd_on_q <= ~pd_dis_q;                                           // R5
    end
  end

  assign reg_rdata_o         = rdata_q;
  assign reg_ack_o           = ack_q;
  assign port_pin_out_o      = pp.pin_level[`PIN_COUNT-1:0];
  assign port_pin_oe_n_o     = pp.pin_drive_n;
  assign internal_pulldown_o = pd_on_q;
  assign output_only_pin_o   = pp.pin_level[`PIN_COUNT];
  assign irq_o               = irq_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  dir_enable_a: assert property (port_pin_oe_n_o == ~$past(dir_q)) // R1
    else $error("pin enable does not follow direction");

  din_latency_a: assert property ($past(reset_n_i, 6) |-> pp.level == $past(port_pin_in_i, 5)) // R3
    else $error("input data does not show pin level five cycles late");

  out_hold_a: assert property ($changed(port_pin_out_o[0]) |=> $stable(port_pin_out_o[0])[*2]) // R12
    else $error("output level held under three cycles");

  xf_hold_a: assert property ($changed(output_only_pin_o) |=> $stable(output_only_pin_o)[*2]) // R4
    else $error("output-only pin level held under three cycles");

  flag_set_a: assert property ((!dir_q[0] && edge_q[0] && pp.rise[0]) |=> flag_q[0]) // R9
    else $error("selected edge not latched in flag");

  flag_fall_a: assert property ((!dir_q[17] && !edge_q[17] && pp.fall[17]) |=> flag_q[17]) // R6
    else $error("falling edge not latched in flag");

  flag_sticky_a: assert property (!wr_flg_w |=> (flag_q & $past(flag_q)) == $past(flag_q)) // R15
    else $error("flag dropped without a clear");

  flag_clear_a: assert property ((wr_flg_w && !hi_w && reg_wdata_i[0] && !evt_w[0]) |=> !flag_q[0]) // R15
    else $error("write of one did not clear flag");

  irq_gate_a: assert property (irq_o == $past(|(flag_q & ien_q))) // R8
    else $error("interrupt line disagrees with enabled flags");

  irq_latency_a: assert property ((!dir_q[0] && edge_q[0] && ien_q[0] && pp.rise[0] && !wr_ien_w) |=> ##1 irq_o) // R16
    else $error("enabled edge did not raise interrupt");

  pulldown_a: assert property (internal_pulldown_o == ~$past(pd_dis_q)) // R5
    else $error("pulldown control does not follow register");

  high_word_a: assert property ((reg_rd_i && hi_w && sel_w != SEL_XF) |=> reg_rdata_o[15:10] == 6'h00) // R7
    else $error("unused high bits of upper word not zero");

  // ****************************************
  // bus and pin checks
  // ****************************************
  ack_pulse_a: assert property ( // R7
    (reg_rd_i || reg_wr_i)
    |=> reg_ack_o)
    else $error("strobe not acknowledged");

  ack_idle_a: assert property ( // R7
    !(reg_rd_i || reg_wr_i)
    |=> !reg_ack_o)
    else $error("acknowledge without a strobe");

  rdata_hold_a: assert property ( // R7
    !reg_rd_i
    |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  flag_read_a: assert property ( // R15
    (reg_rd_i && sel_w == SEL_FLG && !hi_w)
    |=> reg_rdata_o == $past(flag_q[15:0]))
    else $error("flag word read wrong");

  din_readonly_a: assert property ( // R3
    (reg_wr_i && sel_w == SEL_DIN)
    |=> $stable(dir_q) && $stable(dout_q))
    else $error("write to input data changed a register");

  output_no_flag_a: assert property ( // R9
    (dir_q[0] && !flag_q[0])
    |=> !flag_q[0])
    else $error("output pin raised a flag");

  no_edge_a: assert property ( // R9
    (!pp.rise[0] && !pp.fall[0] && !flag_q[0])
    |=> !flag_q[0])
    else $error("flag set without an edge");

  flag_clear_hi_a: assert property ( // R15
    (wr_flg_w && hi_w && reg_wdata_i[1] && !evt_w[17])
    |=> !flag_q[17])
    else $error("write of one did not clear upper flag");

  irq_off_a: assert property ( // R8
    (ien_q == '0)
    |=> !irq_o)
    else $error("interrupt raised with all enables off");

  irq_on_a: assert property ( // R16
    (|(flag_q & ien_q))
    |=> irq_o)
    else $error("enabled flag did not hold interrupt");

  out_follow_a: assert property ( // R2
    $stable(dout_q[0])[*3]
    |-> port_pin_out_o[0] == dout_q[0])
    else $error("output pin does not follow output data");

  xf_follow_a: assert property ( // R4
    $stable(xf_q)[*3]
    |-> output_only_pin_o == xf_q)
    else $error("output-only pin does not follow register");

  unmapped_read_a: assert property ( // R7
    (reg_rd_i && sel_w == SEL_NONE)
    |=> reg_rdata_o == 16'h0000)
    else $error("unmapped word did not read zero");

  xf_read_a: assert property ( // R4
    (reg_rd_i && sel_w == SEL_XF)
    |=> reg_rdata_o[15:1] == 15'h0000)
    else $error("unused bits of output-only word not zero");

endmodule // gpio_port

/* include/gpio_port_consts.svh */
/*
 * constants of the general-purpose pin port: register word addresses,
 * reset values, pin counts and latency / hold counts.
 * assumes a 16-bit word-addressed i/o register port and one system clock.
 */
// What this block does
// R1: each bidirectional pin is set to input or output by its own direction bit.
// R2: a pin set as output drives the level held in its output data bit.
// R3: a pin set as input shows its sampled level in the input data register.
// R4: the port has 26 bidirectional pins plus one pin that is output only.
// R5: each bidirectional pin has a pulldown that software can switch off by itself.
// R6: input edges raise an interrupt, a per-pin bit picking rising or falling edge.
// R7: every port function except the output-only pin is a pair of 16-bit registers holding one bit per pin; that pin has one register.
// R8: a latched edge reaches the interrupt line only while its enable bit is set.
// R9: a qualifying edge is latched in the flag bit whenever the pulse meets the minimum widths.
// R10: the outside keeps an input pulse active for at least two clock periods.
// R11: the outside keeps an input inactive for at least one clock period between pulses.
// R12: each level driven on an output pin lasts at least three clock periods.
// R13: software that polls the input data must ask for pulses long enough for its bus access.
// R14: an input change is seen in input data after 5, in flags after 7, on the interrupt after 8 cycles.
// R15: writing one clears a flag bit, writing zero leaves it, and flags stay set until cleared.
// R16: all enabled pending flags are ored onto one interrupt line held while any remains.
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH

// ****************************************
// pins and word layout
// ****************************************
`define PIN_COUNT      26
`define WORD_BITS      16
`define HI_BITS        10

// ****************************************
// register word addresses
// ****************************************
`define ADDR_DIR_LO    16'h1c06
`define ADDR_DIR_HI    16'h1c07
`define ADDR_DIN_LO    16'h1c08
`define ADDR_DIN_HI    16'h1c09
`define ADDR_DOUT_LO   16'h1c0a
`define ADDR_DOUT_HI   16'h1c0b
`define ADDR_EDGE_LO   16'h1c0c
`define ADDR_EDGE_HI   16'h1c0d
`define ADDR_IEN_LO    16'h1c0e
`define ADDR_IEN_HI    16'h1c0f
`define ADDR_FLG_LO    16'h1c10
`define ADDR_FLG_HI    16'h1c11
`define ADDR_PD_LO     16'h1c12
`define ADDR_PD_HI     16'h1c13
`define ADDR_XF        16'h1c14

// ****************************************
// reset values
// ****************************************
`define RST_PINS       26'h0000000
`define RST_XF         1'b0

// ****************************************
// timing
// ****************************************
`define SYS_CLK_NS     100
`define OUT_HOLD_C     3
`define OUT_HOLD_CYC   ((`OUT_HOLD_C * `SYS_CLK_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define DIN_LAT_CYC    5
`define FLAG_LAT_CYC   7

`endif

/* include/gpio_port_pkg.sv */
/*
 * types shared by the pin port modules.
 * assumes gpio_port_consts.svh is on the include path.
 */
`include "gpio_port_consts.svh"

package gpio_port_pkg;

  // ****************************************
  // types
  // ****************************************
  typedef logic [`WORD_BITS-1:0] word_type;
  typedef logic [`PIN_COUNT-1:0] pins_type;

  typedef enum {
    SEL_NONE,
    SEL_DIR,
    SEL_DIN,
    SEL_DOUT,
    SEL_EDGE,
    SEL_IEN,
    SEL_FLG,
    SEL_PD,
    SEL_XF
  } reg_sel_type;

endpackage

/* include/pin_path_if.sv */
/*
 * carrier between the port core, the input sampler and the output driver.
 * assumes all three parties run on the one system clock.
 */
interface pin_path_if #(
  parameter int W = 26
);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  logic [W:0]   want_level;
  logic [W-1:0] want_drive;
  logic [W:0]   pin_level;
  logic [W-1:0] pin_drive_n;

  modport sampler (input raw, output level, rise, fall);
  modport driver  (input want_level, want_drive, output pin_level, pin_drive_n);
  modport core    (output raw, want_level, want_drive,
                   input level, rise, fall, pin_level, pin_drive_n);
endinterface

/* hw/pin_sampler.sv */
/*
 * input sampler: synchronises the pin levels and delays them to the
 * input-data and edge-flag taps.
 * assumes raw pin levels are asynchronous to core_clk_i.
 */
`include "gpio_port_consts.svh"

module pin_sampler
  import gpio_port_pkg::*;
#(
  parameter int W      = `PIN_COUNT,
  parameter int STAGES = `FLAG_LAT_CYC,
  parameter int TAP    = `DIN_LAT_CYC
) (
  // clock and reset
  input  wire logic  core_clk_i,
  input  wire logic  reset_n_i,
  // pin path
  pin_path_if.sampler pp
);

  // ****************************************
  // delay chain, first two stages synchronise
  // ****************************************
  logic [STAGES-1:0][W-1:0] stage_q;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[STAGES-2:0], pp.raw};
    end
  end

  // taps for input data and edge events
  assign pp.level = stage_q[TAP-1];                                   // R3 R14
  assign pp.rise  = stage_q[STAGES-2] & ~stage_q[STAGES-1];           // R6
  assign pp.fall  = ~stage_q[STAGES-2] & stage_q[STAGES-1];           // R6

endmodule // pin_sampler

/* hw/pin_driver.sv */
/*
 * output driver: registers pin levels and enables, holding each level
 * for a minimum number of cycles.
 * assumes want_level bit W is the output-only pin.
 */
`include "gpio_port_consts.svh"

module pin_driver
  import gpio_port_pkg::*;
#(
  parameter int W    = `PIN_COUNT,
  parameter int HOLD = `OUT_HOLD_CYC
) (
  // clock and reset
  input  wire logic  core_clk_i,
  input  wire logic  reset_n_i,
  // pin path
  pin_path_if.driver pp
);

  // ****************************************
  // drive enables, low while driving
  // ****************************************
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pp.pin_drive_n <= '1;
    end else begin
      pp.pin_drive_n <= ~pp.want_drive;                               // R1
    end
  end

  // ****************************************
  // per-pin level with minimum hold
  // ****************************************
  for (genvar i = 0; i <= W; i++) begin : g_out
    logic [1:0] hold_q;
    logic       may_w;

    assign may_w = (hold_q == 2'(HOLD - 1));

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        pp.pin_level[i] <= 1'b0;
        hold_q          <= 2'(HOLD - 1);
      end else if (may_w && pp.want_level[i] != pp.pin_level[i]) begin
        pp.pin_level[i] <= pp.want_level[i];                          // R2 R12
        hold_q          <= 2'h0;
      end else if (!may_w) begin
        hold_q          <= hold_q + 2'h1;                             // R12
      end
    end
  end

endmodule // pin_driver

/* verification/pin_world_model.sv */
/*
 * outside circuitry on the port pins: resolves each wire from the device
 * drive, the bench drive, the pulldown, or a floating pattern.
 * assumes the bench sets its drive levels at rising clock edges.
 */
`include "gpio_port_consts.svh"

module pin_world_model (
  // clock
  input  wire logic                  core_clk_i,
  // device side
  input  wire logic [`PIN_COUNT-1:0] port_pin_out_i,
  input  wire logic [`PIN_COUNT-1:0] port_pin_oe_n_i,
  input  wire logic [`PIN_COUNT-1:0] internal_pulldown_i,
  // bench side
  input  wire logic [`PIN_COUNT-1:0] ext_en_i,
  input  wire logic [`PIN_COUNT-1:0] ext_level_i,
  output      logic [`PIN_COUNT-1:0] port_pin_in_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [`PIN_COUNT-1:0] float_q = 26'h2aaaaaa;

  // ****************************************
  // undriven wire changes every cycle
  // ****************************************
  always @(posedge core_clk_i) begin
    float_q <= ~float_q;
  end

  // ****************************************
  // wire level per pin
  // ****************************************
  always_comb begin
    for (int k = 0; k < `PIN_COUNT; k++) begin
      if (!port_pin_oe_n_i[k]) begin
        port_pin_in_o[k] = port_pin_out_i[k];
      end else if (ext_en_i[k]) begin
        port_pin_in_o[k] = ext_level_i[k];
      end else if (internal_pulldown_i[k]) begin
        port_pin_in_o[k] = 1'b0;
      end else begin
        port_pin_in_o[k] = float_q[k];
      end
    end
  end
endmodule // pin_world_model

/* verification/tb_gpio_port_with_edge_irq.sv */
/*
 * self-checking bench for the pin port: register tasks, output hold,
 * input edge flags and interrupt.
 * assumes pin_world_model stands on the pins.
 */
`include "gpio_port_consts.svh"

module tb_gpio_port_with_edge_irq;
  timeunit 1ns;
  timeprecision 100ps;

  logic                  core_clk_i = 1'b0;
  logic                  reset_n_i;
  logic [15:0]           reg_addr_i;
  logic                  reg_wr_i;
  logic                  reg_rd_i;
  logic [15:0]           reg_wdata_i;
  logic [15:0]           reg_rdata_o;
  logic                  reg_ack_o;
  logic [`PIN_COUNT-1:0] port_pin_in_i;
  logic [`PIN_COUNT-1:0] port_pin_out_o;
  logic [`PIN_COUNT-1:0] port_pin_oe_n_o;
  logic [`PIN_COUNT-1:0] internal_pulldown_o;
  logic                  output_only_pin_o;
  logic                  irq_o;
  logic [`PIN_COUNT-1:0] ext_en;
  logic [`PIN_COUNT-1:0] ext_level;
  int                    n_errors = 0;
  int                    checked = 0;

  always #50 core_clk_i = ~core_clk_i;

  gpio_port i_gpio_port (
    .core_clk_i         (core_clk_i),
    .reset_n_i          (reset_n_i),
    .reg_addr_i         (reg_addr_i),
    .reg_wr_i           (reg_wr_i),
    .reg_rd_i           (reg_rd_i),
    .reg_wdata_i        (reg_wdata_i),
    .reg_rdata_o        (reg_rdata_o),
    .reg_ack_o          (reg_ack_o),
    .port_pin_in_i      (port_pin_in_i),
    .port_pin_out_o     (port_pin_out_o),
    .port_pin_oe_n_o    (port_pin_oe_n_o),
    .internal_pulldown_o(internal_pulldown_o),
    .output_only_pin_o  (output_only_pin_o),
    .irq_o              (irq_o)
  );

  pin_world_model i_pin_world_model (
    .core_clk_i         (core_clk_i),
    .port_pin_out_i     (port_pin_out_o),
    .port_pin_oe_n_i    (port_pin_oe_n_o),
    .internal_pulldown_i(internal_pulldown_o),
    .ext_en_i           (ext_en),
    .ext_level_i        (ext_level),
    .port_pin_in_o      (port_pin_in_i)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wr_i <= wr;
    reg_rd_i <= !wr;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1;
    check(reg_ack_o, 1'b1);
    q = reg_rdata_o;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    access(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] q;
    access(1'b0, a, 16'h0000, q);
    check(q, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    #(100 * 5000);
    n_errors++;
    end_of_test;
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [15:0] a;
    logic [15:0] rw_list [5];
    int          n;
    rw_list = '{16'h1c06, 16'h1c0a, 16'h1c0c, 16'h1c0e, 16'h1c12};
    reset_n_i = 1'b0;
    reg_addr_i = 16'h0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_wdata_i = 16'h0000;
    ext_en = '1;
    ext_level = '0;
    repeat (16) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    idle(1);
    check(port_pin_oe_n_o, 26'h3ffffff);
    check(internal_pulldown_o, 26'h3ffffff);
    check(irq_o, 1'b0);
    // reset values, unmapped word included
    for (a = 16'h1c06; a <= 16'h1c15; a++) begin
      rd(a, 16'h0000);
    end
    // read-back, high word holds ten pins
    for (int i = 0; i < 5; i++) begin
      wr(rw_list[i], 16'h5a5a);
      rd(rw_list[i], 16'h5a5a);
      wr(rw_list[i] + 16'h0001, 16'hffff);
      rd(rw_list[i] + 16'h0001, 16'h03ff);
    end
    for (int i = 4; i >= 0; i--) begin
      wr(rw_list[i], 16'h0000);
      wr(rw_list[i] + 16'h0001, 16'h0000);
    end
    wr(16'h1c08, 16'hffff);
    idle(12);
    wr(16'h1c10, 16'hffff);
    wr(16'h1c11, 16'hffff);
    rd(16'h1c08, 16'h0000);
    rd(16'h1c10, 16'h0000);
    // output drive and minimum level width
    wr(16'h1c06, 16'h0001);
    idle(1);
    check(port_pin_oe_n_o[0], 1'b0);
    idle(3);
    wr(16'h1c0a, 16'h0001);
    check(port_pin_out_o[0], 1'b0);
    wr(16'h1c0a, 16'h0000);
    check(port_pin_out_o[0], 1'b1);
    idle(1);
    check(port_pin_out_o[0], 1'b1);
    idle(1);
    check(port_pin_out_o[0], 1'b0);
    wr(16'h1c14, 16'h0001);
    idle(1);
    check(output_only_pin_o, 1'b1);
    rd(16'h1c14, 16'h0001);
    wr(16'h1c12, 16'h0001);
    idle(1);
    check(internal_pulldown_o, 26'h3fffffe);
    wr(16'h1c12, 16'h0000);
    wr(16'h1c06, 16'h0000);
    idle(12);
    wr(16'h1c10, 16'hffff);
    // rising edge on pin 0, interrupt latency
    wr(16'h1c0c, 16'h0001);
    wr(16'h1c0e, 16'h0001);
    @(posedge core_clk_i);
    ext_level[0] <= 1'b1;
    for (n = 1; n < 20; n++) begin
      idle(1);
      if (irq_o === 1'b1) break;
    end
    check(n, 8);
    rd(16'h1c08, 16'h0001);
    rd(16'h1c10, 16'h0001);
    wr(16'h1c10, 16'h0000);
    rd(16'h1c10, 16'h0001);
    check(irq_o, 1'b1);
    wr(16'h1c10, 16'h0001);
    rd(16'h1c10, 16'h0000);
    check(irq_o, 1'b0);
    @(posedge core_clk_i);
    ext_level[0] <= 1'b0;
    idle(10);
    rd(16'h1c10, 16'h0000);
    // pin 17: falling edge selected, enable off then on
    @(posedge core_clk_i);
    ext_level[17] <= 1'b1;
    idle(10);
    rd(16'h1c11, 16'h0000);
    @(posedge core_clk_i);
    ext_level[17] <= 1'b0;
    idle(10);
    rd(16'h1c11, 16'h0002);
    check(irq_o, 1'b0);
    wr(16'h1c0f, 16'h0002);
    idle(2);
    check(irq_o, 1'b1);
    end_of_test;
  end
endmodule // tb_gpio_port_with_edge_irq
